// ===== meter_monitor_register_bank.v
// meter monitor register bank: config registers, event flags, logic outputs
// assumes the serial framing delivers one-cycle read and write strobes with
// a byte address, and the measurement datapath supplies synchronous results
`include "meter_consts.vh"

module meter_monitor_register_bank #(
  parameter SAG_TICK_CYCLES = `SAG_LSB_CYCLES,
  parameter PERIOD_TICK_CYCLES = `PERIOD_LSB_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [23:0] reg_wdata,
  input wire reg_rd,
  output reg [23:0] reg_rdata,
  output reg reg_rvalid,
  input wire [23:0] lower_config_sum,
  input wire [23:0] voltage_rms,
  input wire [23:0] current_a_rms,
  input wire [23:0] current_b_rms,
  input wire [11:0] imbalance_threshold,
  input wire [11:0] current_a_peak,
  input wire [11:0] current_b_peak,
  input wire [11:0] voltage_peak,
  input wire zero_cross_event,
  input wire power_negative,
  input wire active_energy_msb,
  input wire apparent_energy_msb,
  input wire channel_b_active,
  input wire vref_low,
  input wire energy_inc_valid,
  input wire [15:0] energy_inc,
  output reg [23:0] line_active_energy,
  output reg line_energy_update,
  output reg [11:0] current_a_cal_gain,
  output reg [11:0] current_b_cal_gain,
  output reg [11:0] voltage_cal_gain,
  output reg [3:0] logic_out,
  output reg irq_n
);

  // ========================================================================
  // register storage
  reg [11:0] energy_accum_period;
  reg [15:0] zero_cross_timeout;
  reg [7:0] sag_duration;
  reg [11:0] sag_level;
  reg [11:0] current_a_peak_level;
  reg [11:0] current_b_peak_level;
  reg [11:0] voltage_peak_level;
  reg [15:0] output_pin_select;
  reg [11:0] irq_enable;

  reg [11:0] irq_flags;
  reg [23:0] last_read_data;
  reg [23:0] last_write_data;
  reg [23:0] config_checksum;
  reg [7:0] write_unlock_key;

  // key gate and flag clear strobe
  wire unlocked = (write_unlock_key == `UNLOCK_VALUE);
  wire cfg_wr = reg_wr & unlocked;
  wire flag_rd = reg_rd & (reg_addr == `OFS_IRQ_FLAGS);

  // protected configuration writes
  always @(posedge clk) begin
    if (!rst_n) begin
      current_a_cal_gain <= 12'h000;
      current_b_cal_gain <= 12'h000;
      voltage_cal_gain <= 12'h000;
      energy_accum_period <= 12'h000;
      zero_cross_timeout <= `RST_ZX_TIMEOUT;
      sag_duration <= `RST_SAG_DURATION;
      sag_level <= `RST_SAG_LEVEL;
      current_a_peak_level <= 12'h000;
      current_b_peak_level <= 12'h000;
      voltage_peak_level <= 12'h000;
      output_pin_select <= 16'h0000;
      irq_enable <= 12'h000;
    end else if (cfg_wr) begin
      case (reg_addr)
        `OFS_CUR_A_GAIN: current_a_cal_gain <= reg_wdata[11:0];
        `OFS_CUR_B_GAIN: current_b_cal_gain <= reg_wdata[11:0];
        `OFS_VOLT_GAIN: voltage_cal_gain <= reg_wdata[11:0];
        `OFS_ACCUM_PERIOD: energy_accum_period <= reg_wdata[11:0];
        `OFS_ZX_TIMEOUT: zero_cross_timeout <= reg_wdata[15:0];
        `OFS_SAG_DURATION: sag_duration <= reg_wdata[7:0];
        `OFS_SAG_LEVEL: sag_level <= reg_wdata[11:0];
        `OFS_CUR_A_PEAK: current_a_peak_level <= reg_wdata[11:0];
        `OFS_CUR_B_PEAK: current_b_peak_level <= reg_wdata[11:0];
        `OFS_VOLT_PEAK: voltage_peak_level <= reg_wdata[11:0];
        `OFS_PIN_SELECT: output_pin_select <= reg_wdata[15:0];
        `OFS_IRQ_ENABLE: irq_enable <= {1'b0, reg_wdata[10:0]};
        default: irq_enable <= irq_enable;
      endcase
    end
  end

  // key register is always writable; last written word captured on any write
  always @(posedge clk) begin
    if (!rst_n) begin
      write_unlock_key <= 8'h00;
      last_write_data <= 24'h000000;
    end else if (reg_wr) begin
      last_write_data <= reg_wdata;
      if (reg_addr == `OFS_UNLOCK_KEY) begin
        write_unlock_key <= reg_wdata[7:0];
      end
    end
  end

  // ========================================================================
  // read path: data one cycle after the strobe, unmapped reads give zero
  reg [23:0] read_mux;

  always @* begin
    case (reg_addr)
      `OFS_CUR_A_GAIN: read_mux = {12'h000, current_a_cal_gain};
      `OFS_CUR_B_GAIN: read_mux = {12'h000, current_b_cal_gain};
      `OFS_VOLT_GAIN: read_mux = {12'h000, voltage_cal_gain};
      `OFS_ACCUM_PERIOD: read_mux = {12'h000, energy_accum_period};
      `OFS_ZX_TIMEOUT: read_mux = {8'h00, zero_cross_timeout};
      `OFS_SAG_DURATION: read_mux = {16'h0000, sag_duration};
      `OFS_SAG_LEVEL: read_mux = {12'h000, sag_level};
      `OFS_CUR_A_PEAK: read_mux = {12'h000, current_a_peak_level};
      `OFS_CUR_B_PEAK: read_mux = {12'h000, current_b_peak_level};
      `OFS_VOLT_PEAK: read_mux = {12'h000, voltage_peak_level};
      `OFS_PIN_SELECT: read_mux = {8'h00, output_pin_select};
      `OFS_IRQ_ENABLE: read_mux = {12'h000, irq_enable};
      `OFS_IRQ_FLAGS: read_mux = {12'h000, irq_flags};
      `OFS_LAST_READ: read_mux = last_read_data;
      `OFS_LAST_WRITE: read_mux = last_write_data;
      `OFS_CHECKSUM: read_mux = config_checksum;
      `OFS_UNLOCK_KEY: read_mux = {16'h0000, write_unlock_key};
      default: read_mux = 24'h000000;
    endcase
  end

  // registered read answer and last-read shadow
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
      last_read_data <= 24'h000000;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_mux;
        last_read_data <= read_mux;
      end
    end
  end

  // ========================================================================
  // checksum over 14h..39h, lower part summed outside this bank
  wire [23:0] own_sum = {12'h000, current_a_cal_gain} + {12'h000, current_b_cal_gain}
    + {12'h000, voltage_cal_gain} + {12'h000, energy_accum_period}
    + {8'h00, zero_cross_timeout} + {16'h0000, sag_duration} + {12'h000, sag_level}
    + {12'h000, current_a_peak_level} + {12'h000, current_b_peak_level}
    + {12'h000, voltage_peak_level} + {8'h00, output_pin_select}
    + {12'h000, irq_enable};

  wire [23:0] next_checksum = lower_config_sum + own_sum;

  // refreshed every cycle, so any change shows one cycle later
  always @(posedge clk) begin
    if (!rst_n) begin
      config_checksum <= `RST_CHECKSUM;
    end else begin
      config_checksum <= next_checksum;
    end
  end

  // ========================================================================
  // zero-crossing timeout: lsb ticks counted since last crossing
  reg [11:0] zx_tick_cnt;
  reg [15:0] zx_lsb_cnt;
  reg zx_missing;

  wire zx_tick = (zx_tick_cnt == `ZX_LSB_CYCLES - 1);
  // crossing restarts the count
  always @(posedge clk) begin
    if (!rst_n) begin
      zx_tick_cnt <= 12'h000;
      zx_lsb_cnt <= 16'h0000;
      zx_missing <= 1'b0;
    end else if (zero_cross_event) begin
      zx_tick_cnt <= 12'h000;
      zx_lsb_cnt <= 16'h0000;
      zx_missing <= 1'b0;
    end else begin
      zx_tick_cnt <= zx_tick ? 12'h000 : zx_tick_cnt + 12'h001;
      if (zx_tick && !zx_missing) begin
        if (zx_lsb_cnt + 16'h0001 >= zero_cross_timeout) begin
          zx_missing <= 1'b1;
        end
        zx_lsb_cnt <= zx_lsb_cnt + 16'h0001;
      end
    end
  end

  // ========================================================================
  // sag: voltage rms below level for the programmed duration
  reg [31:0] sag_tick_cnt;
  reg [7:0] sag_lsb_cnt;
  reg sag_active;

  wire below_level = (voltage_rms[23:12] < sag_level);

  wire sag_tick = (sag_tick_cnt == SAG_TICK_CYCLES - 1);
  always @(posedge clk) begin
    if (!rst_n) begin
      sag_tick_cnt <= 32'h00000000;
      sag_lsb_cnt <= 8'h00;
      sag_active <= 1'b0;
    end else if (!below_level) begin
      sag_tick_cnt <= 32'h00000000;
      sag_lsb_cnt <= 8'h00;
      sag_active <= 1'b0;
    end else begin
      sag_tick_cnt <= sag_tick ? 32'h00000000 : sag_tick_cnt + 32'h00000001;
      if (sag_tick && !sag_active) begin
        if (sag_lsb_cnt + 8'h01 >= sag_duration) begin
          sag_active <= 1'b1;
        end
        sag_lsb_cnt <= sag_lsb_cnt + 8'h01;
      end
    end
  end

  // ========================================================================
  // energy accumulation period with deferred period reload
  reg [31:0] per_tick_cnt;
  reg [11:0] per_lsb_cnt;
  reg [11:0] active_period;
  reg [23:0] energy_accum;

  wire per_tick = (per_tick_cnt == PERIOD_TICK_CYCLES - 1);
  wire period_end = per_tick && (per_lsb_cnt + 12'h001 >= active_period);
  wire [23:0] energy_sum = energy_accum + (energy_inc_valid ? {8'h00, energy_inc} : 24'h000000);

  always @(posedge clk) begin
    if (!rst_n) begin
      per_tick_cnt <= 32'h00000000;
      per_lsb_cnt <= 12'h000;
      active_period <= 12'h000;
      energy_accum <= 24'h000000;
      line_active_energy <= 24'h000000;
      line_energy_update <= 1'b0;
    end else begin
      line_energy_update <= 1'b0;
      per_tick_cnt <= per_tick ? 32'h00000000 : per_tick_cnt + 32'h00000001;
      if (active_period == 12'h000) begin
        active_period <= energy_accum_period; // idle until a period is set
        per_lsb_cnt <= 12'h000;
        energy_accum <= 24'h000000;
      end else if (period_end) begin
        line_active_energy <= energy_sum;
        line_energy_update <= 1'b1;
        energy_accum <= 24'h000000;
        per_lsb_cnt <= 12'h000;
        active_period <= energy_accum_period;
      end else begin
        energy_accum <= energy_sum;
        if (per_tick) begin
          per_lsb_cnt <= per_lsb_cnt + 12'h001;
        end
      end
    end
  end

  // ========================================================================
  // event levels and edge history
  reg power_neg_d;
  reg act_msb_d;
  reg app_msb_d;

  wire peak_a = (current_a_peak > current_a_peak_level);
  wire peak_b = (current_b_peak > current_b_peak_level);
  wire peak_v = (voltage_peak > voltage_peak_level);

  wire [23:0] rms_diff = (current_a_rms > current_b_rms) ? current_a_rms - current_b_rms
    : current_b_rms - current_a_rms;

  wire fault = (rms_diff > {4'h0, imbalance_threshold, 8'h00});

  wire reverse_power_flag_edge = power_negative & ~power_neg_d;
  wire act_hf_edge = active_energy_msb & ~act_msb_d;
  wire app_hf_edge = apparent_energy_msb & ~app_msb_d;

  always @(posedge clk) begin
    if (!rst_n) begin
      power_neg_d <= 1'b0;
      act_msb_d <= 1'b0;
      app_msb_d <= 1'b0;
    end else begin
      power_neg_d <= power_negative;
      act_msb_d <= active_energy_msb;
      app_msb_d <= apparent_energy_msb;
    end
  end

  // sticky status: set by events, cleared by reading, set wins over clear
  wire [11:0] flag_set;

  assign flag_set[`FLG_SAG] = sag_active;
  assign flag_set[`FLG_ZERO_CROSS_MISSING] = zx_missing;
  assign flag_set[`FLG_ZX] = zero_cross_event;
  assign flag_set[`FLG_PEAK_A] = peak_a;
  assign flag_set[`FLG_PEAK_B] = peak_b;
  assign flag_set[`FLG_PEAK_V] = peak_v;
  assign flag_set[`FLG_REVERSE_POWER_FLAG] = reverse_power_flag_edge;
  assign flag_set[`FLG_ACT_HF] = act_hf_edge;
  assign flag_set[`FLG_APP_HF] = app_hf_edge;
  assign flag_set[`FLG_FAULT] = fault;
  assign flag_set[`FLG_CHANNEL_SELECT_FLAG] = channel_b_active;
  assign flag_set[`FLG_VREF_LOW] = vref_low;

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_flags <= 12'h000;
    end else begin
      irq_flags <= (flag_rd ? 12'h000 : irq_flags) | flag_set;
    end
  end

  // interrupt output, active low
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(irq_flags[10:0] & irq_enable[10:0]);
    end
  end

  // ========================================================================
  // logic output pins
  wire [3:0] default_sig = {~sag_active, zero_cross_event, power_negative, fault};

  wire [11:0] route_sig = {channel_b_active, fault, apparent_energy_msb, active_energy_msb,
    power_negative, peak_v, peak_b, peak_a, zero_cross_event, zx_missing, ~sag_active, 1'b0};

  // pick each pin from its 4-bit field
  reg [3:0] next_logic_out;
  reg [3:0] code;
  integer i;

  always @* begin
    next_logic_out = 4'h0;
    code = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      code = output_pin_select[4 * i +: 4];
      if (code == 4'h0) begin
        next_logic_out[i] = default_sig[i];
      end else if (code <= 4'hb) begin
        next_logic_out[i] = route_sig[code];
      end else begin
        next_logic_out[i] = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      logic_out <= 4'h0;
    end else begin
      logic_out <= next_logic_out;
    end
  end

endmodule

// ===== meter_consts.vh
// constants of the meter monitor register bank: offsets, resets, fields, timing
// assumes a 25 MHz clock and a word-wide serial register port outside this bank
//
// Contract
// - three calibration gains hold 12-bit two's-complement values, bit 11 the sign.
// - accumulation period register sets energy update interval, 0.1 s per count.
// - at period end line active energy loads new total, holds until next end.
// - a period written mid-accumulation takes effect only when current period ends.
// - zero-cross missing flag after timeout counts of 70.5 us without crossing.
// - sag uses 8-bit duration at 10 ms per count, level versus rms bits 23:12.
// - output selector holds four 4-bit fields, lowest field drives pin 0.
// - field zero gives default: fault, reverse power, zero cross, active-low sag.
// - codes 1 to 11 route the eleven event signals in order; others reserved.
// - channel select indication is 0 for channel A and 1 for channel B.
// - mask holds enable bits 0 to 10 in flag order, cleared at reset.
// - status bit 11 shows the voltage reference below 2 V.
// - peak flag of a channel sets when its peak exceeds its 12-bit level.
// - reverse power flag sets when active power turns from positive to negative.
// - active and apparent half-full flags set when their accumulator passes half.
// - fault flag sets when rms difference of the current channels exceeds threshold.
// - two read-only 24-bit registers capture the last read and last written data.
// - checksum is the sum of registers 14h to 39h, recomputed on any change.
// - config writes accepted only after key 55h is in the write protection register.
`ifndef METER_CONSTS_VH
`define METER_CONSTS_VH

// ==========================================================================
// register offsets
`define OFS_CUR_A_GAIN 8'h2e
`define OFS_CUR_B_GAIN 8'h2f
`define OFS_VOLT_GAIN 8'h30
`define OFS_ACCUM_PERIOD 8'h31
`define OFS_ZX_TIMEOUT 8'h32
`define OFS_SAG_DURATION 8'h33
`define OFS_SAG_LEVEL 8'h34
`define OFS_CUR_A_PEAK 8'h35
`define OFS_CUR_B_PEAK 8'h36
`define OFS_VOLT_PEAK 8'h37
`define OFS_PIN_SELECT 8'h38
`define OFS_IRQ_ENABLE 8'h39
`define OFS_IRQ_FLAGS 8'h3a
`define OFS_LAST_READ 8'h3b
`define OFS_LAST_WRITE 8'h3c
`define OFS_CHECKSUM 8'h3d
`define OFS_UNLOCK_KEY 8'h3e

// ==========================================================================
// reset values and key
`define RST_ZX_TIMEOUT 16'hffff
`define RST_SAG_DURATION 8'hff
`define RST_SAG_LEVEL 12'h0ff
`define RST_CHECKSUM 24'h0121f2
`define UNLOCK_VALUE 8'h55

// ==========================================================================
// status flag positions
`define FLG_SAG 0
`define FLG_ZERO_CROSS_MISSING 1
`define FLG_ZX 2
`define FLG_PEAK_A 3
`define FLG_PEAK_B 4
`define FLG_PEAK_V 5
`define FLG_REVERSE_POWER_FLAG 6
`define FLG_ACT_HF 7
`define FLG_APP_HF 8
`define FLG_FAULT 9
`define FLG_CHANNEL_SELECT_FLAG 10
`define FLG_VREF_LOW 11

// ==========================================================================
// timing: units in ns, derived cycle counts
`define CLK_PERIOD_NS 40
`define ZX_LSB_NS 70500
`define ZX_LSB_CYCLES (`ZX_LSB_NS / `CLK_PERIOD_NS)
`define SAG_LSB_NS 10000000
`define SAG_LSB_CYCLES (`SAG_LSB_NS / `CLK_PERIOD_NS)
`define PERIOD_LSB_NS 100000000
`define PERIOD_LSB_CYCLES (`PERIOD_LSB_NS / `CLK_PERIOD_NS)

`endif

// ===== meter_bank_assertions.sv
// port checker of the meter monitor register bank
// assumes one clk domain with rst_n synchronous and active low
module meter_bank_checker (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [23:0] reg_wdata,
  input wire reg_rd,
  input wire [23:0] reg_rdata,
  input wire reg_rvalid,
  input wire power_negative,
  input wire channel_b_active,
  input wire [23:0] line_active_energy,
  input wire line_energy_update,
  input wire [11:0] current_a_cal_gain,
  input wire [3:0] logic_out,
  input wire irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] key;
  reg [15:0] sel;
  reg [10:0] en;
  reg [23:0] lw;
  // ==========================================================================
  // port-side copies of key, selector, enables and last write
  always @(posedge clk) begin
    if (!rst_n) begin
      key <= 8'h00;
      sel <= 16'h0000;
      en <= 11'h000;
      lw <= 24'h000000;
    end else if (reg_wr) begin
      lw <= reg_wdata;
      if (reg_addr == 8'h3e) key <= reg_wdata[7:0];
      if (key == 8'h55 && reg_addr == 8'h38) sel <= reg_wdata[15:0];
      if (key == 8'h55 && reg_addr == 8'h39) en <= reg_wdata[10:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // properties
  property p_read_answer; reg_rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read unanswered");
  property p_last_write; reg_rd && reg_addr == 8'h3c |=> reg_rdata == $past(lw); endproperty
  a_last_write: assert property (p_last_write) else $error("last write wrong");
  property p_locked; reg_wr && reg_addr == 8'h2e && key != 8'h55 |=> $stable(current_a_cal_gain);
  endproperty
  a_locked: assert property (p_locked) else $error("locked gain changed");
  property p_unlocked; reg_wr && reg_addr == 8'h2e && key == 8'h55 |=> current_a_cal_gain == lw[11:0];
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("gain not written");
  property p_default_pin1; sel[7:4] == 4'h0 |=> logic_out[1] == $past(power_negative); endproperty
  a_default_pin1: assert property (p_default_pin1) else $error("pin 1 default wrong");
  property p_route_channel_select_flag; sel[3:0] == 4'hb |=> logic_out[0] == $past(channel_b_active); endproperty
  a_route_channel_select_flag: assert property (p_route_channel_select_flag) else $error("channel pin wrong");
  property p_reserved_code; sel[3:0] >= 4'hc |=> !logic_out[0]; endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code drives");
  property p_irq_quiet; (en == 11'h000) [*3] |-> irq_n; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enable");
  property p_energy_hold; !line_energy_update |-> $stable(line_active_energy); endproperty
  a_energy_hold: assert property (p_energy_hold) else $error("energy moved");
  c_last_write: cover property (reg_rd && reg_addr == 8'h3c);
  c_update: cover property (line_energy_update);
  c_irq: cover property (!irq_n);
  c_channel_select_flag: cover property (sel[3:0] == 4'hb);
endmodule

bind meter_monitor_register_bank meter_bank_checker meter_bank_checker_i (.clk, .rst_n,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .power_negative,
  .channel_b_active, .line_active_energy, .line_energy_update, .current_a_cal_gain,
  .logic_out, .irq_n);

// ===== host_model.sv
// host side of the register port: one strobed access at a time
// assumes strobes taken at a rising clk and rvalid one cycle later
module host_model (
  input wire clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [23:0] reg_wdata,
  output logic reg_rd,
  input wire [23:0] reg_rdata,
  input wire reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 24'h000000;
    reg_rd = 1'b0;
  end
  // one write; idle lines then show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read; ok stays low if rvalid never comes
  task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    d = 24'h000000;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = reg_rvalid;
      d = reg_rdata;
    end
  endtask
  // the key goes in before any calibration write
  task automatic unlock;
    wr(8'h3e, 24'h000055);
  endtask
  // gain for a negative error in ppm, usable down to -33.3 percent
  function automatic logic [11:0] neg_gain(input int e_ppm);
    return 12'((4096 * -e_ppm) / (1000000 + e_ppm));
  endfunction
endmodule

// ===== meter_monitor_register_bank_test.sv
// self-checking bench of the meter monitor register bank
// assumes host_model on the register port and the bound port checker
module meter_monitor_register_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire [7:0] reg_addr;
  wire reg_wr;
  wire [23:0] reg_wdata;
  wire reg_rd;
  wire [23:0] reg_rdata;
  wire reg_rvalid;
  logic [23:0] lower_config_sum = 24'h001ff5;
  logic [23:0] current_a_rms = 24'h000000;
  logic [23:0] voltage_rms = 24'hfff000;
  logic [11:0] current_a_peak = 12'h000;
  logic [11:0] current_b_peak = 12'h000;
  logic [11:0] voltage_peak = 12'h000;
  logic zero_cross_event = 1'b0;
  logic power_negative = 1'b0;
  logic active_energy_msb = 1'b0;
  logic apparent_energy_msb = 1'b0;
  logic channel_b_active = 1'b0;
  logic vref_low = 1'b0;
  logic energy_inc_valid = 1'b0;
  logic [15:0] energy_inc = 16'h0000;
  wire [23:0] line_active_energy;
  wire line_energy_update;
  wire [11:0] current_a_cal_gain;
  wire [3:0] logic_out;
  wire irq_n;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'h50660488;
  logic [23:0] sh [0:16] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'hffff, 24'hff, 24'hff, 24'h0, 24'h0,
    24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0121f2, 24'h0};
  logic [23:0] mk [0:11] = '{24'hfff, 24'hfff, 24'hfff, 24'hfff, 24'hffff, 24'hff, 24'hfff,
    24'hfff, 24'hfff, 24'hfff, 24'hffff, 24'h7ff};
  initial forever #20 clk = ~clk;
  meter_monitor_register_bank #(.SAG_TICK_CYCLES(4), .PERIOD_TICK_CYCLES(8))
    meter_monitor_register_bank_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .lower_config_sum(lower_config_sum), .voltage_rms(voltage_rms),
    .current_a_rms(current_a_rms), .current_b_rms(24'h000000), .imbalance_threshold(12'h001),
    .current_a_peak(current_a_peak), .current_b_peak(current_b_peak),
    .voltage_peak(voltage_peak), .zero_cross_event(zero_cross_event),
    .power_negative(power_negative), .active_energy_msb(active_energy_msb),
    .apparent_energy_msb(apparent_energy_msb), .channel_b_active(channel_b_active),
    .vref_low(vref_low), .energy_inc_valid(energy_inc_valid), .energy_inc(energy_inc),
    .line_active_energy(line_active_energy), .line_energy_update(line_energy_update),
    .current_a_cal_gain(current_a_cal_gain), .current_b_cal_gain(), .voltage_cal_gain(),
    .logic_out(logic_out), .irq_n(irq_n));
  host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [23:0] cksum();
    logic [23:0] s;
    s = lower_config_sum;
    for (int j = 0; j < 12; j++) s += sh[j];
    return s;
  endfunction
  function automatic int pin_exp(input logic [3:0] c);
    case (c)
      4'h3: return zero_cross_event;
      4'h7: return power_negative;
      4'h8: return active_energy_msb;
      4'h9: return apparent_energy_msb;
      4'ha: return current_a_rms[9];
      4'hb: return channel_b_active;
      4'h1: return 1;
      4'h4, 4'h5, 4'h6, 4'hc, 4'hd, 4'he, 4'hf: return 0;
      default: return -1;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic ok;
    host_model_i.rd(a, d, ok);
    if (!ok) begin
      fail_count++;
      tally_and_finish;
    end
    chk(d, exp);
  endtask
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (line_energy_update !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task automatic set_ev(input int b, input logic v);
    case (b)
      0: voltage_rms <= {{12{~v}}, 12'h000};
      2: zero_cross_event <= v;
      3: current_a_peak <= {11'h000, v};
      4: current_b_peak <= {11'h000, v};
      5: voltage_peak <= {11'h000, v};
      6: power_negative <= v;
      7: active_energy_msb <= v;
      8: apparent_energy_msb <= v;
      9: current_a_rms <= {14'h0000, v, 9'h000};
      10: channel_b_active <= v;
      default: vref_low <= v;
    endcase
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] r;
    int i;
    int n;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 17; j++)
      if (j != 13 && j != 14) rdc(8'(8'h2e + j), sh[j]);
    rdc(8'h10, 24'h000000);
    host_model_i.wr(8'h2e, 24'h000abc);
    rdc(8'h3c, 24'h000abc);
    chk(current_a_cal_gain, 24'h000000);
    $display("done: reset values and lock");
    r = rnd();
    lower_config_sum <= r[23:0];
    host_model_i.unlock();
    host_model_i.wr(8'h2e, {12'h000, host_model_i.neg_gain(-50000)});
    sh[0] = 24'h0000d7;
    rdc(8'h2e, sh[0]);
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      i = r[27:24] % 12;
      host_model_i.wr(8'(8'h2e + i), r[23:0]);
      sh[i] = r[23:0] & mk[i];
      rdc(8'(8'h2e + i), sh[i]);
      rdc(8'h3b, sh[i]);
      rdc(8'h3c, r[23:0]);
      rdc(8'h3d, cksum());
    end
    host_model_i.wr(8'h3d, 24'h123456);
    rdc(8'h3d, cksum());
    chk(current_a_cal_gain, sh[0]);
    $display("done: random register access");
    for (int c = 0; c < 16; c++) begin
      host_model_i.wr(8'h38, 24'(c));
      r = rnd();
      power_negative <= r[0];
      active_energy_msb <= r[1];
      apparent_energy_msb <= r[2];
      channel_b_active <= r[3];
      zero_cross_event <= r[4];
      current_a_rms <= {14'h0000, r[5], 9'h000};
      repeat (3) @(posedge clk);
      n = pin_exp(c[3:0]);
      if (c == 0)
        chk(logic_out, {1'b1, zero_cross_event, power_negative, current_a_rms[9]});
      else if (n >= 0)
        chk(logic_out[0], n[0]);
    end
    for (int b = 2; b < 12; b++) set_ev(b, 1'b0);
    $display("done: logic outputs");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    host_model_i.unlock();
    host_model_i.wr(8'h39, 24'h000fff);
    host_model_i.wr(8'h33, 24'h000001);
    host_model_i.wr(8'h32, 24'h000001);
    for (int b = 0; b < 12; b++) begin
      if (b == 1) continue;
      set_ev(b, 1'b1);
      repeat (8) @(posedge clk);
      set_ev(b, 1'b0);
      repeat (3) @(posedge clk);
      chk(irq_n, b == 11);
      rdc(8'h3a, 24'h000001 << b);
      rdc(8'h3a, 24'h000000);
    end
    $display("done: event flags");
    r = rnd();
    energy_inc_valid <= 1'b1;
    energy_inc <= r[15:0];
    host_model_i.wr(8'h31, 24'h000002);
    wait_upd(n);
    wait_upd(n);
    chk(n, 16);
    chk(line_active_energy, {4'h0, r[15:0], 4'h0});
    fork
      host_model_i.wr(8'h31, 24'h000001);
      wait_upd(n);
    join
    chk(n, 16);
    wait_upd(n);
    chk(n, 8);
    chk(line_active_energy, {5'h00, r[15:0], 3'h0});
    repeat (1800) @(posedge clk);
    rdc(8'h3a, 24'h000002);
    $display("done: energy period");
    tally_and_finish();
  end
endmodule
